// ==== fcs_flash_cmd_seq.sv ====
// Flash command sequencer: APB registers, command buffer, pulse timer
// Operation
// - Divider sets 150-200 kHz timing clock; no command before it is written.
// - Divider register is writable once after reset; later writes ignored.
// - Divider writes are blocked while the access error flag is set.
// - Program and erase pulses last whole timing clock periods; here the timing clock runs free, so a pulse's first period may be short.
// - Byte program takes 9 timing cycles, burst byte takes 4.
// - Page erase takes 4000 cycles, mass erase 20000 cycles.
// - Sequence starts with an array write; address and data are latched.
// - Page erase uses any page address; erase and blank ignore data.
// - Second step writes the command code into the command buffer.
// - Page erase 0x40 and mass erase 0x41 complete five valid codes.
// - Writing 1 to buffer-empty flag clears it and launches command.
// - Writing 0 to buffer-empty flag aborts the sequence, sets access error.
// - Command-complete flag shows when launched command has finished.
// - Charge pump turns on at command start, off at completion.
// - Pump stays on only if next burst is queued and same row.
// - Low six address bits select row byte; zero starts new row.
// - First burst byte takes standard time, following bytes burst time.
// - No queued burst at completion turns the pump off.
// - Matching 8-byte key unlocks when enabled, only from secure code.
// - Key disabled: only mass erase plus blank verify unlocks.
// - Security state 1:0 means unsecured.
// - Secured part denies RAM to debug and non-secure code.
// - Access error clears by writing 1; no command while set.
// - Array write while buffer-empty flag is clear sets access error.
// - Blocked secure accesses ignore writes and read back zero.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module fcs_flash_cmd_seq #(
  parameter logic [14:0] PAGE_CYC = fcs_pkg::FCS_CYC_PAGE,
  parameter logic [14:0] MASS_CYC = fcs_pkg::FCS_CYC_MASS
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   acc_from_debug,
  input  wire logic                   acc_from_secure,
  input  wire logic [7:0]             nv_opt,
  input  wire logic [63:0]            nv_key,
  input  wire logic [7:0]             flash_rdata,
  input  wire logic                   array_blank,
  output fcs_pkg::fcs_flash_req_t     flash_req,
  output logic                        pump_en,
  output logic                        sec_engaged,
  output logic                        ram_deny
);

  // Timing clock terminal count: (div + 1) times 1 or 8, minus one
  function automatic logic [9:0] flash_timing_clock_last(input logic [7:0] d);
    logic [9:0] n;
    n = {4'h0, d[5:0]} + 10'h001;
    if (d[fcs_pkg::FCS_DIV_PRE8])
      n = {n[6:0], 3'h0};
    flash_timing_clock_last = n - 10'h001;
  endfunction

  // Command code to operation; anything else is illegal
  function automatic fcs_pkg::fcs_op_t code_op(input logic [7:0] c);
    case (c)
      fcs_pkg::FCS_CMD_BLANK:  code_op = fcs_pkg::FCS_OP_BLANK;
      fcs_pkg::FCS_CMD_PROG:   code_op = fcs_pkg::FCS_OP_PROG;
      fcs_pkg::FCS_CMD_BURST:  code_op = fcs_pkg::FCS_OP_BURST;
      fcs_pkg::FCS_CMD_PERASE: code_op = fcs_pkg::FCS_OP_PERASE;
      fcs_pkg::FCS_CMD_MERASE: code_op = fcs_pkg::FCS_OP_MERASE;
      default:                 code_op = fcs_pkg::FCS_OP_NONE;
    endcase
  endfunction

  logic [7:0]               div_reg;
  logic [7:0]               opt_reg;
  logic                     opt_ld_reg;
  logic                     keyacc_reg;
  logic                     cbef_reg;
  logic                     accerr_reg;
  logic                     blank_reg;
  logic                     erased_reg;
  fcs_pkg::fcs_seq_t        seq_reg;
  logic [15:0]              baddr_reg;
  logic [7:0]               bdata_reg;
  logic [7:0]               bcmd_reg;
  logic                     pend_reg;
  fcs_pkg::fcs_ex_t         ex_reg;
  fcs_pkg::fcs_flash_req_t  req_reg;
  logic [9:0]               pre_reg;
  logic [14:0]              tcnt_reg;
  logic                     pump_reg;
  logic                     chained_reg;
  logic [63:0]              kbuf_reg;
  logic [3:0]               kcnt_reg;
  logic                     kbad_reg;
  logic [31:0]              prdata_reg;
  logic                     pready_reg;
  logic                     pslverr_reg;
  logic                     sec_reg;
  logic                     deny_reg;
  logic [14:0]              ticks_reg;
  logic [7:0]               rd_val;

  // Address decode; the array window sits above the control registers
  wire logic hit_arr  = paddr[fcs_pkg::FCS_ARR_BIT] & (paddr[31:17] == 15'h0);
  wire logic hit_reg  = (paddr[31:8] == 24'h0);
  wire logic sel_div  = hit_reg & (paddr[7:0] == fcs_pkg::FCS_OFF_DIV);
  wire logic sel_opt  = hit_reg & (paddr[7:0] == fcs_pkg::FCS_OFF_OPT);
  wire logic sel_cfg  = hit_reg & (paddr[7:0] == fcs_pkg::FCS_OFF_CFG);
  wire logic sel_stat = hit_reg & (paddr[7:0] == fcs_pkg::FCS_OFF_STAT);
  wire logic sel_cmd  = hit_reg & (paddr[7:0] == fcs_pkg::FCS_OFF_CMD);
  wire logic sel_ctl  = sel_div | sel_opt | sel_cfg | sel_stat | sel_cmd;
  wire logic mapped   = hit_arr | sel_ctl;
  wire logic xfer     = psel & penable;
  wire logic fin      = xfer & pready_reg;
  wire logic wr       = fin & pwrite;

  // Security view of the current accessor
  wire logic sec_on    = opt_reg[1:0] != fcs_pkg::FCS_SEC_OPEN;
  wire logic untrusted = acc_from_debug | ~acc_from_secure;
  wire logic blocked   = sec_on & untrusted;
  wire logic backdoor_key_enable     = opt_reg[fcs_pkg::FCS_OPT_BACKDOOR_KEY_ENABLE];
  wire logic key_mode  = keyacc_reg & backdoor_key_enable;

  // Array writes: key entry, blocked, or first command step
  wire logic key_wr  = wr & hit_arr & key_mode & ~untrusted;
  wire logic arr_wr  = wr & hit_arr & ~key_mode & ~blocked;
  wire logic arr_bad = ~div_reg[fcs_pkg::FCS_DIV_LD] | ~cbef_reg
                     | (seq_reg != fcs_pkg::FCS_SEQ_IDLE) | accerr_reg;
  wire logic arr_ok  = arr_wr & ~arr_bad;

  // Command code step; a secured debug host may only blank check or mass erase
  wire fcs_pkg::fcs_op_t wop = code_op(pwdata[7:0]);
  wire logic dbg_deny = acc_from_debug & sec_on
                      & (wop != fcs_pkg::FCS_OP_BLANK)
                      & (wop != fcs_pkg::FCS_OP_MERASE);
  wire logic cmd_ok = wr & sel_cmd & (seq_reg == fcs_pkg::FCS_SEQ_DATA)
                    & (wop != fcs_pkg::FCS_OP_NONE) & ~dbg_deny;

  // Launch, abort and protocol violations
  wire logic ctl_wr  = wr & sel_ctl;
  wire logic stat_wr = wr & sel_stat;
  wire logic launch  = stat_wr & pwdata[fcs_pkg::FCS_ST_CBEF]
                     & (seq_reg == fcs_pkg::FCS_SEQ_CMD);
  wire logic abort   = stat_wr & ~pwdata[fcs_pkg::FCS_ST_CBEF]
                     & (seq_reg != fcs_pkg::FCS_SEQ_IDLE);
  wire logic seq_err =
      ((seq_reg == fcs_pkg::FCS_SEQ_IDLE) & wr & sel_cmd)
    | ((seq_reg == fcs_pkg::FCS_SEQ_DATA) & ctl_wr & ~cmd_ok)
    | ((seq_reg == fcs_pkg::FCS_SEQ_CMD) & fin & sel_ctl & ~launch)
    | (arr_wr & arr_bad & ~accerr_reg);
  wire logic acc_clr = stat_wr & pwdata[fcs_pkg::FCS_ST_ACCERR];

  // Divider and configuration writes
  wire logic div_wr = wr & sel_div & ~div_reg[fcs_pkg::FCS_DIV_LD]
                    & ~accerr_reg;
  wire logic cfg_wr = wr & sel_cfg & ~untrusted;
  wire logic key_chk = cfg_wr & keyacc_reg
                     & ~pwdata[fcs_pkg::FCS_CFG_KEYACC];
  wire logic key_hit = key_chk & backdoor_key_enable & ~kbad_reg & (kcnt_reg == 4'h8)
                     & (kbuf_reg == nv_key);
  wire logic kpos_ok = (paddr[15:0] == fcs_pkg::FCS_KEY_BASE
                       + {12'h000, kcnt_reg}) & ~kcnt_reg[3];

  // Timing clock enable; no edge until the divider is written
  wire logic tick = div_reg[fcs_pkg::FCS_DIV_LD]
                  & (pre_reg == flash_timing_clock_last(div_reg));
  wire logic run  = ex_reg == fcs_pkg::FCS_EX_RUN;
  wire logic end_ev = run & tick & (tcnt_reg == 15'h0001);

  // Blank check after mass erase is the keyless way back to unsecured
  wire logic unlock_blank = end_ev & (req_reg.op == fcs_pkg::FCS_OP_BLANK)
                          & array_blank & erased_reg;

  // Buffered command hand-off and burst chaining
  wire fcs_pkg::fcs_op_t bop = code_op(bcmd_reg);
  wire logic same_row = (baddr_reg[15:fcs_pkg::FCS_ROW_BITS]
                         == req_reg.addr[15:fcs_pkg::FCS_ROW_BITS])
                      & (baddr_reg[fcs_pkg::FCS_ROW_BITS-1:0] != 6'h00);
  wire logic chain = end_ev & (req_reg.op == fcs_pkg::FCS_OP_BURST)
                   & pend_reg & (bop == fcs_pkg::FCS_OP_BURST)
                   & same_row;
  wire logic take_idle = pend_reg & ~run;
  wire logic take = take_idle | chain;
  wire logic ccf = ~pend_reg & ~run;

  // Pulse length of the command being taken
  logic [14:0] dur;
  always_comb
  begin
    unique case (bop)
      fcs_pkg::FCS_OP_PERASE: dur = PAGE_CYC;
      fcs_pkg::FCS_OP_MERASE: dur = MASS_CYC;
      fcs_pkg::FCS_OP_BLANK:  dur = fcs_pkg::FCS_CYC_BLANK;
      default:                dur = fcs_pkg::FCS_CYC_PROG;
    endcase
    if (chain)
      dur = fcs_pkg::FCS_CYC_BURST;
  end

  // Register read mux; blocked array reads return zero
  always_comb
  begin
    rd_val = 8'h00;
    if (sel_div)
      rd_val = div_reg;
    if (sel_opt)
      rd_val = opt_reg;
    if (sel_cfg)
      rd_val = {2'h0, keyacc_reg, 5'h00};
    if (sel_stat)
      rd_val = {cbef_reg, ccf, 1'h0, accerr_reg, 1'h0, blank_reg, 2'h0};
    if (sel_cmd)
      rd_val = bcmd_reg;
    if (hit_arr & ~blocked)
      rd_val = flash_rdata;
  end

  // APB answer: one wait state so every answer comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= xfer & ~pready_reg;
      if (xfer & ~pready_reg)
      begin
        prdata_reg  <= pwrite ? 32'h0 : {24'h0, rd_val};
        pslverr_reg <= ~mapped;
      end
    end
  end

  // Divider, options and access error flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg    <= fcs_pkg::FCS_DIV_RST;
      opt_reg    <= fcs_pkg::FCS_OPT_RST;
      opt_ld_reg <= 1'b0;
      accerr_reg <= 1'b0;
      keyacc_reg <= 1'b0;
    end
    else
    begin
      if (div_wr)
        div_reg <= {1'b1, pwdata[6:0]};
      // Options copied once after reset release; secured until then
      opt_ld_reg <= 1'b1;
      if (!opt_ld_reg)
        opt_reg <= nv_opt;
      else if (key_hit | unlock_blank)
        opt_reg[1:0] <= fcs_pkg::FCS_SEC_OPEN;
      accerr_reg <= seq_err | (accerr_reg & ~acc_clr);
      if (cfg_wr)
        keyacc_reg <= pwdata[fcs_pkg::FCS_CFG_KEYACC];
    end
  end

  // Backdoor key capture, in ascending address order
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kbuf_reg <= 64'h0;
      kcnt_reg <= 4'h0;
      kbad_reg <= 1'b0;
    end
    else if (cfg_wr & pwdata[fcs_pkg::FCS_CFG_KEYACC] & ~keyacc_reg)
    begin
      kcnt_reg <= 4'h0;
      kbad_reg <= 1'b0;
    end
    else if (key_wr)
    begin
      kbuf_reg <= {kbuf_reg[55:0], pwdata[7:0]};
      kcnt_reg <= kcnt_reg + 4'h1;
      kbad_reg <= kbad_reg | ~kpos_ok;
    end
  end

  // Command sequence: array write, code write, launch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_reg   <= fcs_pkg::FCS_SEQ_IDLE;
      baddr_reg <= 16'h0;
      bdata_reg <= 8'h00;
      bcmd_reg  <= 8'h00;
      cbef_reg  <= 1'b1;
      pend_reg  <= 1'b0;
    end
    else
    begin
      unique case (seq_reg)
        fcs_pkg::FCS_SEQ_IDLE:
          if (arr_ok)
            seq_reg <= fcs_pkg::FCS_SEQ_DATA;
        fcs_pkg::FCS_SEQ_DATA:
          if (cmd_ok)
            seq_reg <= fcs_pkg::FCS_SEQ_CMD;
          else if (seq_err)
            seq_reg <= fcs_pkg::FCS_SEQ_IDLE;
        fcs_pkg::FCS_SEQ_CMD:
          if (launch | seq_err)
            seq_reg <= fcs_pkg::FCS_SEQ_IDLE;
      endcase
      if (arr_ok)
      begin
        baddr_reg <= paddr[15:0];
        bdata_reg <= pwdata[7:0];
      end
      if (cmd_ok)
        bcmd_reg <= pwdata[7:0];
      // Launch and take never coincide: launch needs an empty buffer
      if (launch)
      begin
        cbef_reg <= 1'b0;
        pend_reg <= 1'b1;
      end
      else if (take)
      begin
        cbef_reg <= 1'b1;
        pend_reg <= 1'b0;
      end
    end
  end

  // Executor: pulse timer in timing clock periods and charge pump
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ex_reg      <= fcs_pkg::FCS_EX_IDLE;
      req_reg     <= '0;
      tcnt_reg    <= 15'h0;
      pump_reg    <= 1'b0;
      chained_reg <= 1'b0;
      blank_reg   <= 1'b0;
      erased_reg  <= 1'b0;
      pre_reg     <= 10'h0;
    end
    else
    begin
      pre_reg <= tick | ~div_reg[fcs_pkg::FCS_DIV_LD] ? 10'h0
               : pre_reg + 10'h001;
      if (take)
      begin
        ex_reg       <= fcs_pkg::FCS_EX_RUN;
        req_reg.op   <= bop;
        req_reg.addr <= baddr_reg;
        // Erase and blank check carry no data to the array
        req_reg.data <= (bop == fcs_pkg::FCS_OP_PROG
                        | bop == fcs_pkg::FCS_OP_BURST)
                        ? bdata_reg : 8'h00;
        tcnt_reg     <= dur;
        pump_reg     <= 1'b1;
        chained_reg  <= chain;
        blank_reg    <= 1'b0;
        if (bop != fcs_pkg::FCS_OP_BLANK & bop != fcs_pkg::FCS_OP_MERASE)
          erased_reg <= 1'b0;
      end
      else if (end_ev)
      begin
        ex_reg   <= fcs_pkg::FCS_EX_IDLE;
        req_reg  <= '0;
        pump_reg <= 1'b0;
        if (req_reg.op == fcs_pkg::FCS_OP_BLANK)
          blank_reg <= array_blank;
        if (req_reg.op == fcs_pkg::FCS_OP_MERASE)
          erased_reg <= 1'b1;
      end
      else if (run & tick)
        tcnt_reg <= tcnt_reg - 15'h0001;
    end
  end

  // Security outputs, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_reg  <= 1'b1;
      deny_reg <= 1'b1;
    end
    else
    begin
      sec_reg  <= sec_on;
      deny_reg <= blocked;
    end
  end

  // Timing periods seen by the running command, for the checks below
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ticks_reg <= 15'h0;
    else if (take)
      ticks_reg <= 15'h0;
    else if (run & tick)
      ticks_reg <= ticks_reg + 15'h0001;
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign flash_req   = req_reg;
  assign pump_en     = pump_reg;
  assign sec_engaged = sec_reg;
  assign ram_deny    = deny_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_once: assert property (
    div_reg[fcs_pkg::FCS_DIV_LD] |=> div_reg == $past(div_reg))
    else $error("divider changed after first write");
  a_div_accerr: assert property (
    wr & sel_div & accerr_reg |=> div_reg == $past(div_reg))
    else $error("divider written while access error set");
  a_nodiv_err: assert property (
    arr_wr & ~div_reg[fcs_pkg::FCS_DIV_LD] |=> accerr_reg
      && seq_reg == fcs_pkg::FCS_SEQ_IDLE)
    else $error("array write accepted before divider");
  a_prog_std: assert property (
    end_ev & req_reg.op == fcs_pkg::FCS_OP_PROG
      |-> ticks_reg == fcs_pkg::FCS_CYC_PROG - 15'h0001)
    else $error("byte program length wrong");
  a_burst_len: assert property (
    end_ev & chained_reg
      |-> ticks_reg == fcs_pkg::FCS_CYC_BURST - 15'h0001)
    else $error("burst byte length wrong");
  a_page_len: assert property (
    end_ev & req_reg.op == fcs_pkg::FCS_OP_PERASE
      |-> ticks_reg == PAGE_CYC - 15'h0001)
    else $error("page erase length wrong");
  a_launch_buf: assert property (
    launch |=> ~cbef_reg & pend_reg ##1 cbef_reg | pend_reg)
    else $error("launch did not fill the buffer");
  a_abort_err: assert property (
    abort |=> accerr_reg & ~pend_reg
      & (seq_reg == fcs_pkg::FCS_SEQ_IDLE))
    else $error("abort did not flag access error");
  a_pump_run: assert property (
    run |-> pump_reg)
    else $error("pump off during a command");
  a_pump_drop: assert property (
    end_ev & ~chain |=> ~pump_reg & ~run)
    else $error("pump held without queued burst");
  a_block_read: assert property (
    xfer & ~pready_reg & ~pwrite & hit_arr & blocked
      |=> pready_reg & prdata_reg == 32'h0)
    else $error("blocked array read returned data");
endmodule

// ==== fcs_flash_model.sv ====
// Behavioural flash array with blank flag, facing the sequencer
`timescale 1ns/1ps
module fcs_flash_model (
  input  wire logic                    pclk,
  input  wire fcs_pkg::fcs_flash_req_t req,
  output logic [7:0]                   rdata,
  output logic                         blank
);
  // Fixed read pattern; a blocked read must not show it
  assign rdata = 8'ha5;
  initial blank = 1'b0;
  // Mass erase leaves the array blank, any program dirties it
  always @(posedge pclk)
  begin
    if (req.op == fcs_pkg::FCS_OP_MERASE)
      blank <= 1'b1;
    else if (req.op == fcs_pkg::FCS_OP_PROG)
      blank <= 1'b0;
    else if (req.op == fcs_pkg::FCS_OP_BURST)
      blank <= 1'b0;
  end
endmodule

// ==== fcs_pkg.sv ====
// Constants and types shared by the flash command sequencer
package fcs_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] FCS_OFF_DIV  = 8'h00;
  localparam logic [7:0] FCS_OFF_OPT  = 8'h04;
  localparam logic [7:0] FCS_OFF_CFG  = 8'h08;
  localparam logic [7:0] FCS_OFF_STAT = 8'h0c;
  localparam logic [7:0] FCS_OFF_CMD  = 8'h10;
  // paddr bit that selects the flash array window
  localparam int FCS_ARR_BIT = 16;
  // Field positions
  localparam int FCS_DIV_LD     = 7;
  localparam int FCS_DIV_PRE8   = 6;
  localparam int FCS_OPT_BACKDOOR_KEY_ENABLE  = 7;
  localparam int FCS_CFG_KEYACC = 5;
  localparam int FCS_ST_CBEF    = 7;
  localparam int FCS_ST_CCF     = 6;
  localparam int FCS_ST_ACCERR  = 4;
  localparam int FCS_ST_BLANK   = 2;
  localparam int FCS_ROW_BITS   = 6;
  // Reset values and security encoding
  localparam logic [7:0] FCS_DIV_RST = 8'h00;
  localparam logic [7:0] FCS_OPT_RST = 8'h00;
  localparam logic [1:0] FCS_SEC_OPEN = 2'h2;
  // Command codes
  localparam logic [7:0] FCS_CMD_BLANK  = 8'h05;
  localparam logic [7:0] FCS_CMD_PROG   = 8'h20;
  localparam logic [7:0] FCS_CMD_BURST  = 8'h25;
  localparam logic [7:0] FCS_CMD_PERASE = 8'h40;
  localparam logic [7:0] FCS_CMD_MERASE = 8'h41;
  // First backdoor key location in the array
  localparam logic [15:0] FCS_KEY_BASE = 16'hffb0;
  // Timing clock window and pulse lengths in timing clock cycles
  localparam int FCS_FLASH_TIMING_CLOCK_MIN_KHZ = 150;
  localparam int FCS_FLASH_TIMING_CLOCK_MAX_KHZ = 200;
  localparam logic [14:0] FCS_CYC_PROG  = 15'h0009;
  localparam logic [14:0] FCS_CYC_BURST = 15'h0004;
  localparam logic [14:0] FCS_CYC_PAGE  = 15'h0fa0;
  localparam logic [14:0] FCS_CYC_MASS  = 15'h4e20;
  localparam logic [14:0] FCS_CYC_BLANK = 15'h0001;

  typedef enum logic [2:0] {
    FCS_OP_NONE, FCS_OP_BLANK, FCS_OP_PROG, FCS_OP_BURST,
    FCS_OP_PERASE, FCS_OP_MERASE
  } fcs_op_t;

  typedef struct packed {
    fcs_op_t     op;
    logic [15:0] addr;
    logic [7:0]  data;
  } fcs_flash_req_t;

  typedef enum logic [1:0] {FCS_SEQ_IDLE, FCS_SEQ_DATA, FCS_SEQ_CMD} fcs_seq_t;
  typedef enum logic {FCS_EX_IDLE, FCS_EX_RUN} fcs_ex_t;
endpackage

// ==== tb_top.sv ====
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] DIV = 32'h3;
  localparam int          P   = 4;
  localparam logic [31:0] AW  = 32'h10000;
  localparam logic [31:0] ST  = 32'h0c;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        acc_from_debug, acc_from_secure, pump_en, sec_engaged;
  logic        ram_deny, array_blank;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0]  nv_opt, flash_rdata, d;
  logic [15:0] a;
  logic [63:0] nv_key;
  fcs_pkg::fcs_flash_req_t flash_req, last_req;
  int          mismatches, cmp_count, run, last_run, runs, seed, i, r0;
  int          cyc[3] = '{9, 10, 20};
  logic [7:0]  code[3] = '{8'h20, 8'h40, 8'h41};
  fcs_flash_cmd_seq #(.PAGE_CYC(15'h000a), .MASS_CYC(15'h0014)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_from_debug(acc_from_debug),
    .acc_from_secure(acc_from_secure), .nv_opt(nv_opt), .nv_key(nv_key),
    .flash_rdata(flash_rdata), .array_blank(array_blank),
    .flash_req(flash_req), .pump_en(pump_en), .sec_engaged(sec_engaged),
    .ram_deny(ram_deny));
  fcs_flash_model model (.pclk(pclk), .req(flash_req),
    .rdata(flash_rdata), .blank(array_blank));
  // Free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Pump run lengths and the request each command presented
  always @(posedge pclk)
  begin
    if (pump_en === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      last_run <= run;
      runs <= runs + 1;
      run <= 0;
    end
    if (flash_req.op != fcs_pkg::FCS_OP_NONE)
      last_req <= flash_req;
  end
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(string n, int lo, int hi, int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic tmo(int n, int lim);
    if (n >= lim)
    begin
      mismatches++;
      $display("CHECK FAILED wait expected answer seen none");
      end_sim();
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [31:0] ad, logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tmo(n, 20);
  endtask
  task automatic run_cmd(logic [15:0] ad, logic [7:0] dd, logic [7:0] c);
    apb(1'b1, AW | ad, dd);
    apb(1'b1, 32'h10, c);
    apb(1'b1, ST, 32'h80);
  endtask
  // Poll until buffer empty and command complete
  task automatic wdone();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ST, 0);
      n++;
    end
    while (rd[7:6] !== 2'b11 && n < 60);
    tmo(n, 60);
  endtask
  task automatic key_in();
    apb(1'b1, 32'h08, 32'h20);
    for (int k = 0; k < 8; k++)
      apb(1'b1, AW | (32'hffb0 + k), {24'h0, nv_key[63-8*k -: 8]});
    apb(1'b1, 32'h08, 0);
    repeat (2) @(posedge pclk);
  endtask
  task automatic rst(logic [7:0] o);
    presetn <= 1'b0;
    nv_opt <= o;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // Main sequence
  initial
  begin
    seed = 71474;
    {psel, penable, pwrite, acc_from_debug, presetn} = 5'h0;
    acc_from_secure = 1'b1;
    paddr = 0;
    pwdata = 0;
    nv_opt = 8'h02;
    {run, runs, last_run, mismatches, cmp_count} = 0;
    nv_key = {$random(seed), $random(seed)};
    rst(8'h02);
    chk("sec", 0, sec_engaged);
    apb(1'b1, AW, 8'h11);
    apb(1'b1, 0, DIV);
    apb(1'b0, 0, 0);
    chk("div", 0, rd);
    apb(1'b1, ST, 32'h10);
    apb(1'b1, 0, DIV);
    apb(1'b1, 0, 32'h07);
    apb(1'b0, 0, 0);
    chk("div", 32'h80 | DIV, rd);
    // Abort, double array write, bad code: launch then has no effect
    for (i = 1; i < 4; i++)
    begin
      d = $random(seed);
      if (d == 8'h05 || d[7:1] == 7'h10 || d[7:1] == 7'h12 || d[7:1] == 7'h20)
        d = 8'h21;
      apb(1'b1, AW, 0);
      if (i == 1)
        apb(1'b1, ST, 0);
      else
        apb(1'b1, i == 2 ? AW : 32'h10, d);
      apb(1'b1, ST, 32'h80);
      repeat (3) @(posedge pclk);
      chk("pump", 0, pump_en);
      apb(1'b0, ST, 0);
      chk("accerr", 1, rd[4]);
      apb(1'b1, ST, 32'h10);
    end
    apb(1'b0, 32'h14, 0);
    chk("slverr", 1, err);
    apb(1'b0, AW, 0);
    chk("rdarr", 32'ha5, rd);
    $display("Refusal tests done");
    // Program, page erase, mass erase timed by the pump, then blank check
    for (i = 0; i < 3; i++)
    begin
      d = $random(seed);
      a = $random(seed);
      run_cmd(a, d, code[i]);
      apb(1'b0, ST, 0);
      chk("busy", 0, rd[6]);
      wdone();
      chk_rng("run", (cyc[i]-1)*P+1, cyc[i]*P+1, last_run);
      chk("addr", a, last_req.addr);
      chk("data", i ? 8'h00 : d, last_req.data);
    end
    run_cmd(a, 0, 8'h05);
    wdone();
    chk("blank", 1, rd[2]);
    $display("Command tests done");
    // Queued burst: same row keeps pump on, a row start drops it
    for (i = 0; i < 2; i++)
    begin
      r0 = runs;
      a = i ? 16'h123f : 16'h1230;
      run_cmd(a, 8'h3c, 8'h25);
      run_cmd(a + 16'h1, 8'hc3, 8'h25);
      wdone();
      chk("runs", r0 + 1 + i, runs);
      chk_rng("burst", i ? 8*P+1 : 11*P+1, i ? 9*P+1 : 13*P+2, last_run);
    end
    $display("Burst tests done");
    // Secured part with key enabled: debug key refused, secure key opens
    rst(8'h83);
    apb(1'b1, 0, DIV);
    acc_from_debug <= 1'b1;
    key_in();
    chk("sec", 1, sec_engaged);
    chk("ramdeny", 1, ram_deny);
    apb(1'b0, AW, 0);
    chk("blocked", 0, rd);
    acc_from_debug <= 1'b0;
    key_in();
    chk("sec", 0, sec_engaged);
    chk("ramdeny", 0, ram_deny);
    // Key disabled: only mass erase plus blank check opens
    rst(8'h03);
    apb(1'b1, 0, DIV);
    key_in();
    chk("sec", 1, sec_engaged);
    // Key writes were taken as array steps and flagged; clear that first
    apb(1'b1, ST, 32'h10);
    run_cmd(16'h0, 0, 8'h41);
    wdone();
    run_cmd(16'h0, 0, 8'h05);
    wdone();
    repeat (2) @(posedge pclk);
    chk("sec", 0, sec_engaged);
    $display("Security tests done");
    end_sim();
  end
endmodule
